// *** rtl/palette_ext_map.sv ***
// Purpose: Maps a host palette index onto the standard or extended table entry.
// Assumes: Extended table holds 16 entries from 256 upward.
// Notes: Purely combinational; caller registers the result.
module palette_ext_map (
  input wire logic ext_access_in,
  input wire logic icon_3color_in,
  input wire logic [7:0] host_index_in,
  output logic [8:0] entry_out,
  output logic reserved_out
);
  logic [3:0] code;
  assign code = host_index_in[3:0];
  always_comb begin
    reserved_out = 1'b0;
    if (!ext_access_in) begin
      entry_out = {1'b0, host_index_in}; // R03
    end else begin
      if (code == seq_ext_pkg::EXT_BG_CODE) begin
        entry_out = seq_ext_pkg::CURSOR_BG_ENTRY; // R04
      end else if (code == seq_ext_pkg::EXT_FG_CODE) begin
        entry_out = seq_ext_pkg::CURSOR_FG_ENTRY; // R04
      end else if (code == seq_ext_pkg::EXT_SPARE_CODE) begin
        // Index X1h takes the slot left free by the foreground colour
        entry_out = seq_ext_pkg::SPARE_X1_ENTRY;
      end else begin
        entry_out = seq_ext_pkg::EXT_BASE | {5'h00, code}; // R03
      end
      if (code >= seq_ext_pkg::ICON_FIRST && code <= seq_ext_pkg::ICON_LAST) begin
        reserved_out = icon_3color_in; // R05
      end else if (code >= seq_ext_pkg::RSVD_FIRST && code <= seq_ext_pkg::RSVD_LAST) begin
        reserved_out = 1'b1;
      end
    end
  end
endmodule

// *** rtl/seq_ext_cursor_sig_regs.sv ***
// Purpose: Sequencer extension registers for cursor, palette access, memory map and signature.
// Assumes: Host reaches registers through an index port and a data port, each with a read strobe and a write strobe.
// Notes: Data reads answer one cycle after the strobe on io_rdata_out.
// Overview of operation
// R01: Border colour from attribute field or entry 258
// R02: Size bit picks 32x32 or 64x64 cursor
// R03: Extended bit switches host to 16 extra entries
// R04: X0h, XFh, X2h map to 256, 257, 258
// R05: X3h-X6h icon colours, reserved in three-colour mode
// R06: Enable bit shows or hides the cursor
// R07: Small cursor: five bits pick 32 patterns
// R08: Large cursor: bits 4:2 pick 8 patterns
// R09: Patterns live in 8K within top 32K
// R10: Pattern register bit 5 always reads one
// R11: Two scratch pads reset zero, firmware only
// R12: Retry bit re-reads after memory read time-out
// R13: Clear map bit, zero segment, map 01: segmented
// R14: Map bit, non-zero segment: linear at 3FFF00
// R15: Subsystem ID writable only when bit set
// R16: Enable maps block-transfer registers as 36 bytes
// R17: Bit 7 enables block-transfer signature generator
// R18: Bit 6 stops pixel clock and pixel drivers
// R19: Bit 5 puts pseudo-random data on memory
// R20: Select field picks luma bit or panel colour
// R21: Start bit runs one frame, then clears
// R22: Sixteen-bit result read as low, high bytes
// R23: Reset bit zeroes the accumulated signature
module seq_ext_cursor_sig_regs #(
  parameter int MEM_ADDR_W = 22,
  parameter int MEM_DATA_W = 64
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic io_index_wr_in,
  input wire logic io_index_rd_in,
  input wire logic io_data_wr_in,
  input wire logic io_data_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  input wire logic [7:0] host_pal_index_in,
  input wire logic icon_3color_in,
  input wire logic [5:0] attribute_border_field_in,
  input wire logic [3:0] linear_segment_field_in,
  input wire logic [1:0] graphics_memory_map_field_in,
  input wire logic mem_read_timeout_in,
  input wire logic [21:0] host_mem_addr_in,
  input wire logic frame_start_in,
  input wire logic pixel_valid_in,
  input wire logic [7:0] video_port_luma_bits_in,
  input wire logic [2:0] panel_rgb_in,
  input wire logic panel_mode_in,
  input wire logic [MEM_DATA_W-1:0] mem_data_in,
  output logic cursor_enable_out,
  output logic cursor_large_out,
  output logic [MEM_ADDR_W-1:0] cursor_pattern_addr_out,
  output logic [8:0] palette_table_entry_out,
  output logic palette_reserved_out,
  output logic [8:0] border_entry_out,
  output logic border_from_attr_out,
  output logic mem_read_retry_out,
  output logic mmio_segmented_out,
  output logic mmio_linear_out,
  output logic blit_mmio_enable_out,
  output logic blit_mmio_hit_out,
  output logic subsystem_id_wr_en_out,
  output logic blit_sig_enable_out,
  output logic pixel_clock_disable_out,
  output logic [MEM_DATA_W-1:0] mem_data_out,
  output logic sig_busy_out
);
  generate
    if (MEM_ADDR_W < seq_ext_pkg::CURSOR_TOP_BITS || MEM_ADDR_W > 32) begin : g_bad_addr
      $error("MEM_ADDR_W must cover the cursor region");
    end
    if (MEM_DATA_W < 16 || MEM_DATA_W % 16 != 0) begin : g_bad_data
      $error("MEM_DATA_W must be a multiple of 16");
    end
  endgenerate

  logic [7:0] index_q;
  logic [7:0] attr_q;
  logic [7:0] pattern_q;
  logic [7:0] scratch2_q;
  logic [7:0] scratch3_q;
  logic [7:0] map_q;
  logic [7:0] sig_q;
  logic [7:0] sig_d;
  logic [7:0] rdata_q;
  logic [8:0] pal_entry;
  logic pal_rsvd;
  logic [12:0] pat_offset;

  sig_link_if link ();

  function automatic logic [7:0] read_mux(input logic [7:0] idx, input logic [7:0] attr,
      input logic [7:0] pat, input logic [7:0] s2, input logic [7:0] s3,
      input logic [7:0] map, input logic [7:0] sig, input logic [15:0] res);
    logic [7:0] v;
    v = 8'h00;
    if (idx == seq_ext_pkg::IDX_CURSOR_ATTR) begin
      v = attr;
    end else if (idx == seq_ext_pkg::IDX_PATTERN) begin
      v = (pat & seq_ext_pkg::PAT_RW_MASK) | (8'h01 << seq_ext_pkg::PAT_RO_ONE); // R10
    end else if (idx == seq_ext_pkg::IDX_SCRATCH2) begin
      v = s2;
    end else if (idx == seq_ext_pkg::IDX_SCRATCH3) begin
      v = s3;
    end else if (idx == seq_ext_pkg::IDX_MAP_CTRL) begin
      v = map;
    end else if (idx == seq_ext_pkg::IDX_SIG_CTRL) begin
      v = sig;
    end else if (idx == seq_ext_pkg::IDX_SIG_LOW) begin
      v = res[7:0]; // R22
    end else if (idx == seq_ext_pkg::IDX_SIG_HIGH) begin
      v = res[15:8]; // R22
    end
    return v;
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [7:0] idx,
      input logic [7:0] target);
    return wr && idx == target;
  endfunction

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      index_q <= seq_ext_pkg::REG_RESET;
    end else if (io_index_wr_in) begin
      index_q <= io_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      attr_q <= seq_ext_pkg::REG_RESET;
      pattern_q <= seq_ext_pkg::REG_RESET;
      map_q <= seq_ext_pkg::REG_RESET;
    end else begin
      if (wr_hit(io_data_wr_in, index_q, seq_ext_pkg::IDX_CURSOR_ATTR)) begin
        attr_q <= io_wdata_in & seq_ext_pkg::ATTR_RW_MASK;
      end
      if (wr_hit(io_data_wr_in, index_q, seq_ext_pkg::IDX_PATTERN)) begin
        pattern_q <= io_wdata_in & seq_ext_pkg::PAT_RW_MASK;
      end
      if (wr_hit(io_data_wr_in, index_q, seq_ext_pkg::IDX_MAP_CTRL)) begin
        map_q <= io_wdata_in & seq_ext_pkg::MAP_RW_MASK;
      end
    end
  end

  // Scratch pads belong to firmware; hardware stores them and never alters them
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scratch2_q <= seq_ext_pkg::REG_RESET; // R11
      scratch3_q <= seq_ext_pkg::REG_RESET; // R11
    end else begin
      if (wr_hit(io_data_wr_in, index_q, seq_ext_pkg::IDX_SCRATCH2)) begin
        scratch2_q <= io_wdata_in;
      end
      if (wr_hit(io_data_wr_in, index_q, seq_ext_pkg::IDX_SCRATCH3)) begin
        scratch3_q <= io_wdata_in;
      end
    end
  end

  // A host write that sets start in the done cycle wins over the hardware clear
  always_comb begin
    sig_d = sig_q;
    if (link.done) begin
      sig_d[seq_ext_pkg::SIG_START] = 1'b0; // R21
    end
    if (wr_hit(io_data_wr_in, index_q, seq_ext_pkg::IDX_SIG_CTRL)) begin
      sig_d = io_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sig_q <= seq_ext_pkg::REG_RESET;
    end else begin
      sig_q <= sig_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
    end else if (io_index_rd_in) begin
      rdata_q <= index_q;
    end else if (io_data_rd_in) begin
      rdata_q <= read_mux(index_q, attr_q, pattern_q, scratch2_q, scratch3_q, map_q, sig_q,
        link.result);
    end
  end

  assign io_rdata_out = rdata_q;

  assign link.start = sig_q[seq_ext_pkg::SIG_START]; // R21
  assign link.clear = sig_q[seq_ext_pkg::SIG_CLR]; // R23
  assign link.sel = sig_q[seq_ext_pkg::SIG_SEL_HI:seq_ext_pkg::SIG_SEL_LO]; // R20
  assign link.panel_mode = panel_mode_in;
  assign link.prng_en = sig_q[seq_ext_pkg::SIG_PRNG];

  sig_gen u_sig_gen (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .link(link),
    .frame_start_in(frame_start_in),
    .pixel_valid_in(pixel_valid_in),
    .luma_in(video_port_luma_bits_in),
    .panel_rgb_in(panel_rgb_in)
  );

  palette_ext_map u_palette_ext_map (
    .ext_access_in(attr_q[seq_ext_pkg::ATTR_EXT]),
    .icon_3color_in(icon_3color_in),
    .host_index_in(host_pal_index_in),
    .entry_out(pal_entry),
    .reserved_out(pal_rsvd)
  );

  // Small patterns are 256 bytes apart, large ones 1 Kbyte; both fill 8 Kbytes
  always_comb begin
    if (attr_q[seq_ext_pkg::ATTR_SIZE]) begin
      pat_offset = {pattern_q[4:2], 10'h000}; // R08
    end else begin
      pat_offset = {pattern_q[4:0], 8'h00}; // R07
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cursor_pattern_addr_out <= '0;
      palette_table_entry_out <= 9'h000;
      palette_reserved_out <= 1'b0;
      border_entry_out <= 9'h000;
      border_from_attr_out <= 1'b1;
    end else begin
      // Region is the topmost 8 Kbytes, inside the top 32 Kbytes
      cursor_pattern_addr_out <= {{(MEM_ADDR_W - seq_ext_pkg::CURSOR_REGION_BITS){1'b1}},
        pat_offset}; // R09
      palette_table_entry_out <= pal_entry; // R03
      palette_reserved_out <= pal_rsvd; // R05
      if (attr_q[seq_ext_pkg::ATTR_PROTECT]) begin
        border_entry_out <= seq_ext_pkg::BORDER_ENTRY; // R01
        border_from_attr_out <= 1'b0;
      end else begin
        border_entry_out <= {3'h0, attribute_border_field_in}; // R01
        border_from_attr_out <= 1'b1;
      end
    end
  end

  assign cursor_enable_out = attr_q[seq_ext_pkg::ATTR_ENABLE]; // R06
  assign cursor_large_out = attr_q[seq_ext_pkg::ATTR_SIZE]; // R02
  assign blit_mmio_enable_out = map_q[seq_ext_pkg::MAP_MMIO_EN]; // R16
  assign subsystem_id_wr_en_out = map_q[seq_ext_pkg::MAP_SUBSYS_WR]; // R15
  assign blit_sig_enable_out = sig_q[seq_ext_pkg::SIG_BLIT]; // R17
  assign pixel_clock_disable_out = sig_q[seq_ext_pkg::SIG_PCLK_OFF]; // R18
  assign sig_busy_out = sig_q[seq_ext_pkg::SIG_START];

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mem_read_retry_out <= 1'b0;
      mmio_segmented_out <= 1'b0;
      mmio_linear_out <= 1'b0;
      blit_mmio_hit_out <= 1'b0;
    end else begin
      mem_read_retry_out <= map_q[seq_ext_pkg::MAP_RETRY] && mem_read_timeout_in; // R12
      mmio_segmented_out <= map_q[seq_ext_pkg::MAP_MMIO_EN] && !map_q[seq_ext_pkg::MAP_LINEAR]
        && linear_segment_field_in == seq_ext_pkg::SEG_FIELD_ZERO
        && graphics_memory_map_field_in == seq_ext_pkg::GR_MAP_SEGMENTED; // R13
      mmio_linear_out <= map_q[seq_ext_pkg::MAP_MMIO_EN] && map_q[seq_ext_pkg::MAP_LINEAR]
        && linear_segment_field_in != seq_ext_pkg::SEG_FIELD_ZERO; // R14
      blit_mmio_hit_out <= map_q[seq_ext_pkg::MAP_MMIO_EN] && map_q[seq_ext_pkg::MAP_LINEAR]
        && linear_segment_field_in != seq_ext_pkg::SEG_FIELD_ZERO
        && host_mem_addr_in >= seq_ext_pkg::LINEAR_MMIO_BASE
        && host_mem_addr_in < seq_ext_pkg::LINEAR_MMIO_BASE + seq_ext_pkg::BLIT_MMIO_BYTES; // R16
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mem_data_out <= '0;
    end else if (sig_q[seq_ext_pkg::SIG_PRNG]) begin
      mem_data_out <= {(MEM_DATA_W / 16){link.prng}}; // R19
    end else begin
      mem_data_out <= mem_data_in;
    end
  end

  pattern_ro_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R10
    io_data_rd_in && !io_index_rd_in && index_q == seq_ext_pkg::IDX_PATTERN
    |=> io_rdata_out[5]) else $error("pattern bit 5 not one");

  border_pick_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R01
    attr_q[seq_ext_pkg::ATTR_PROTECT] |=> border_entry_out == 9'h102)
    else $error("border not from entry 258");

  border_attr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R01
    !attr_q[seq_ext_pkg::ATTR_PROTECT]
    |=> border_entry_out == {3'h0, $past(attribute_border_field_in)})
    else $error("border not from attribute field");

  read_retry_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R12
    mem_read_timeout_in |=> mem_read_retry_out == $past(map_q[seq_ext_pkg::MAP_RETRY]))
    else $error("retry wrong");

  linear_map_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R14
    mmio_linear_out |-> !mmio_segmented_out && $past(linear_segment_field_in) != 4'h0)
    else $error("linear map wrong");

  segment_map_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R13
    map_q[seq_ext_pkg::MAP_MMIO_EN] && !map_q[seq_ext_pkg::MAP_LINEAR]
    && linear_segment_field_in == 4'h0 && graphics_memory_map_field_in == 2'h1
    |=> mmio_segmented_out) else $error("segmented map missing");

  large_pattern_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R08
    attr_q[seq_ext_pkg::ATTR_SIZE] |=> cursor_pattern_addr_out[9:0] == 10'h000)
    else $error("large pattern misaligned");

  small_pattern_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R07
    !attr_q[seq_ext_pkg::ATTR_SIZE] |=> cursor_pattern_addr_out[12:8] == $past(pattern_q[4:0]))
    else $error("small pattern wrong");

  start_done_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R21
    link.done && !io_data_wr_in |=> !sig_q[seq_ext_pkg::SIG_START])
    else $error("start not cleared on done");

  scratch_keep_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R11
    !io_data_wr_in |=> scratch2_q == $past(scratch2_q) && scratch3_q == $past(scratch3_q))
    else $error("scratch pad changed");

  cursor_bg_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R04
    attr_q[seq_ext_pkg::ATTR_EXT] && host_pal_index_in[3:0] == 4'h0
    |=> palette_table_entry_out == 9'h100) else $error("background entry wrong");

  cursor_fg_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R04
    attr_q[seq_ext_pkg::ATTR_EXT] && host_pal_index_in[3:0] == 4'hf
    |=> palette_table_entry_out == 9'h101) else $error("foreground entry wrong");

  std_palette_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R03
    !attr_q[seq_ext_pkg::ATTR_EXT]
    |=> palette_table_entry_out == {1'b0, $past(host_pal_index_in)})
    else $error("standard entry wrong");

  icon_reserved_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R05
    attr_q[seq_ext_pkg::ATTR_EXT] && host_pal_index_in[3:0] >= 4'h3
    && host_pal_index_in[3:0] <= 4'h6 |=> palette_reserved_out == $past(icon_3color_in))
    else $error("icon reservation wrong");

  result_high_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R22
    io_data_rd_in && !io_index_rd_in && index_q == seq_ext_pkg::IDX_SIG_HIGH
    |=> io_rdata_out == $past(link.result[15:8])) else $error("result high wrong");
endmodule

// *** rtl/seq_ext_pkg.sv ***
// Purpose: Shared constants for the sequencer extension register group.
// Assumes: Registers sit behind an 8-bit index port and an 8-bit data port.
// Notes: Field positions are bit numbers inside the 8-bit registers.
package seq_ext_pkg;
  localparam logic [7:0] IDX_CURSOR_ATTR = 8'h12;
  localparam logic [7:0] IDX_PATTERN = 8'h13;
  localparam logic [7:0] IDX_SCRATCH2 = 8'h14;
  localparam logic [7:0] IDX_SCRATCH3 = 8'h15;
  localparam logic [7:0] IDX_MAP_CTRL = 8'h17;
  localparam logic [7:0] IDX_SIG_CTRL = 8'h18;
  localparam logic [7:0] IDX_SIG_LOW = 8'h19;
  localparam logic [7:0] IDX_SIG_HIGH = 8'h1a;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ATTR_RW_MASK = 8'h87;
  localparam int ATTR_PROTECT = 7;
  localparam int ATTR_SIZE = 2;
  localparam int ATTR_EXT = 1;
  localparam int ATTR_ENABLE = 0;
  localparam logic [7:0] PAT_RW_MASK = 8'h1f;
  localparam int PAT_RO_ONE = 5;
  localparam logic [7:0] MAP_RW_MASK = 8'hcc;
  localparam int MAP_RETRY = 7;
  localparam int MAP_LINEAR = 6;
  localparam int MAP_SUBSYS_WR = 3;
  localparam int MAP_MMIO_EN = 2;
  localparam int SIG_BLIT = 7;
  localparam int SIG_PCLK_OFF = 6;
  localparam int SIG_PRNG = 5;
  localparam int SIG_SEL_HI = 4;
  localparam int SIG_SEL_LO = 2;
  localparam int SIG_CLR = 1;
  localparam int SIG_START = 0;
  localparam logic [8:0] EXT_BASE = 9'h100;
  localparam logic [8:0] CURSOR_BG_ENTRY = 9'h100;
  localparam logic [8:0] CURSOR_FG_ENTRY = 9'h101;
  localparam logic [8:0] BORDER_ENTRY = 9'h102;
  localparam logic [8:0] SPARE_X1_ENTRY = 9'h10f;
  localparam logic [3:0] EXT_BG_CODE = 4'h0;
  localparam logic [3:0] EXT_SPARE_CODE = 4'h1;
  localparam logic [3:0] EXT_FG_CODE = 4'hf;
  localparam logic [3:0] ICON_FIRST = 4'h3;
  localparam logic [3:0] ICON_LAST = 4'h6;
  localparam logic [3:0] RSVD_FIRST = 4'ha;
  localparam logic [3:0] RSVD_LAST = 4'hd;
  localparam int CURSOR_REGION_BITS = 13;
  localparam int CURSOR_TOP_BITS = 15;
  localparam int SMALL_PAT_SHIFT = 8;
  localparam int LARGE_PAT_SHIFT = 10;
  localparam logic [21:0] LINEAR_MMIO_BASE = 22'h3fff00;
  localparam logic [21:0] BLIT_MMIO_BYTES = 22'h000024;
  localparam logic [3:0] SEG_FIELD_ZERO = 4'h0;
  localparam logic [1:0] GR_MAP_SEGMENTED = 2'h1;
  localparam logic [1:0] PANEL_NONE_SEL = 2'h3;
  localparam logic [15:0] MISR_TAPS = 16'h8016;
  localparam logic [15:0] PRNG_TAPS = 16'hb400;
  localparam logic [15:0] PRNG_SEED = 16'h0001;
endpackage

// *** rtl/sig_gen.sv ***
// Purpose: Frame signature accumulator and pseudo-random word source.
// Assumes: frame_start_in pulses once per frame, pixel_valid_in once per pixel.
// Notes: Capture runs from the first frame start after arming to the next one.
module sig_gen (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  sig_link_if.gen link,
  input wire logic frame_start_in,
  input wire logic pixel_valid_in,
  input wire logic [7:0] luma_in,
  input wire logic [2:0] panel_rgb_in
);
  typedef enum {SIG_IDLE, SIG_WAIT, SIG_RUN} sig_state_t;
  sig_state_t state_q;
  logic [15:0] misr_q;
  logic [15:0] prng_q;
  logic done_q;
  logic in_bit;

  always_comb begin
    in_bit = luma_in[link.sel];
    if (link.panel_mode) begin
      in_bit = (link.sel[1:0] == seq_ext_pkg::PANEL_NONE_SEL) ? 1'b0
        : panel_rgb_in[link.sel[1:0]]; // R20
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !link.start || link.clear) begin
      state_q <= SIG_IDLE;
    end else begin
      case (state_q)
        SIG_IDLE: state_q <= SIG_WAIT;
        SIG_WAIT: if (frame_start_in) state_q <= SIG_RUN;
        SIG_RUN: if (frame_start_in) state_q <= SIG_IDLE; // R21
        default: state_q <= SIG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    done_q <= !sys_rst_in && link.start && !link.clear && state_q == SIG_RUN && frame_start_in;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || link.clear) begin
      misr_q <= 16'h0000; // R23
    end else if (state_q == SIG_WAIT && frame_start_in) begin
      misr_q <= 16'h0000;
    end else if (state_q == SIG_RUN && pixel_valid_in && !frame_start_in) begin
      misr_q <= {misr_q[14:0], 1'b0} ^ (misr_q[15] ? seq_ext_pkg::MISR_TAPS : 16'h0000)
        ^ {15'h0000, in_bit};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prng_q <= seq_ext_pkg::PRNG_SEED;
    end else if (link.prng_en) begin
      prng_q <= {prng_q[14:0], ^(prng_q & seq_ext_pkg::PRNG_TAPS)}; // R19
    end
  end

  assign link.done = done_q;
  assign link.result = misr_q;
  assign link.prng = prng_q;

  result_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R23
    link.clear |=> misr_q == 16'h0000) else $error("signature not cleared");
  prng_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R19
    link.prng_en && $past(link.prng_en) |-> prng_q != $past(prng_q))
    else $error("prng stalled");
endmodule

// *** rtl/sig_link_if.sv ***
// Purpose: Carries signature control and results between register bank and generator.
// Assumes: Single clock domain.
// Notes: done is a one-cycle pulse at end of the captured frame.
interface sig_link_if;
  logic start;
  logic clear;
  logic panel_mode;
  logic [2:0] sel;
  logic prng_en;
  logic done;
  logic [15:0] result;
  logic [15:0] prng;
  modport ctrl (output start, clear, panel_mode, sel, prng_en, input done, result, prng);
  modport gen (input start, clear, panel_mode, sel, prng_en, output done, result, prng);
endinterface

// *** sim/host_io_model.sv ***
// Purpose: Host processor model for the indexed register port.
// Assumes: Strobes change 1 ns after the rising clock edge.
// Notes: Every access is an index write followed by one data strobe.
module host_io_model (
  input wire logic clk_in,
  input wire logic [7:0] io_rdata_in,
  output logic io_index_wr_out,
  output logic io_data_wr_out,
  output logic io_data_rd_out,
  output logic [7:0] io_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    io_index_wr_out = 1'b0;
    io_data_wr_out = 1'b0;
    io_data_rd_out = 1'b0;
    io_wdata_out = 8'h00;
  end
  task automatic set_index(input logic [7:0] idx);
    @(posedge clk_in) #1;
    io_index_wr_out = 1'b1;
    io_wdata_out = idx;
    @(posedge clk_in) #1;
    io_index_wr_out = 1'b0;
  endtask
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    set_index(idx);
    io_data_wr_out = 1'b1;
    io_wdata_out = d;
    @(posedge clk_in) #1;
    io_data_wr_out = 1'b0;
    io_wdata_out = ~d;
  endtask
  task automatic get(input logic [7:0] idx, output logic [7:0] d);
    set_index(idx);
    io_data_rd_out = 1'b1;
    @(posedge clk_in) #1;
    io_data_rd_out = 1'b0;
    @(posedge clk_in) #1;
    d = io_rdata_in;
  endtask
endmodule

// *** sim/seq_ext_cursor_sig_regs_tb.sv ***
// Purpose: Self-checking bench for the sequencer extension registers.
// Assumes: 100 MHz clock, synchronous reset held four cycles.
// Notes: Signatures are checked after eight pixels of a constant input bit.
module seq_ext_cursor_sig_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic iw, dw, dr, fs, pv, icon3, tmo, panel, cen, clg, prsv, battr;
  logic retry, mseg, mlin, men, mhit, subwr, bsig, pclkoff, busy;
  logic [7:0] wdata, rdata, pal_idx, luma;
  logic [5:0] attr;
  logic [3:0] seg;
  logic [1:0] gmap;
  logic [2:0] rgb;
  logic [21:0] maddr, paddr;
  logic [8:0] pentry, bentry;
  logic [63:0] mdin, mdout;
  logic [15:0] res;
  logic [7:0] ctls [4] = '{8'h05, 8'h01, 8'h0d, 8'h01};
  logic [3:0] nz = 4'b1010;
  logic [7:0] pidx [5] = '{8'h00, 8'h0f, 8'h02, 8'h03, 8'h06};
  logic [8:0] pent [5] = '{9'h100, 9'h101, 9'h102, 9'h103, 9'h106};
  int err_count = 0;
  int tests_run = 0;
  always #5 clk_in = ~clk_in;
  host_io_model u_host (.clk_in(clk_in), .io_rdata_in(rdata), .io_index_wr_out(iw),
    .io_data_wr_out(dw), .io_data_rd_out(dr), .io_wdata_out(wdata));
  seq_ext_cursor_sig_regs u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .io_index_wr_in(iw), .io_index_rd_in(1'b0), .io_data_wr_in(dw), .io_data_rd_in(dr),
    .io_wdata_in(wdata), .io_rdata_out(rdata), .host_pal_index_in(pal_idx),
    .icon_3color_in(icon3), .attribute_border_field_in(attr), .linear_segment_field_in(seg),
    .graphics_memory_map_field_in(gmap), .mem_read_timeout_in(tmo),
    .host_mem_addr_in(maddr), .frame_start_in(fs), .pixel_valid_in(pv),
    .video_port_luma_bits_in(luma), .panel_rgb_in(rgb), .panel_mode_in(panel),
    .mem_data_in(mdin), .cursor_enable_out(cen), .cursor_large_out(clg),
    .cursor_pattern_addr_out(paddr), .palette_table_entry_out(pentry),
    .palette_reserved_out(prsv), .border_entry_out(bentry), .border_from_attr_out(battr),
    .mem_read_retry_out(retry), .mmio_segmented_out(mseg), .mmio_linear_out(mlin),
    .blit_mmio_enable_out(men), .blit_mmio_hit_out(mhit), .subsystem_id_wr_en_out(subwr),
    .blit_sig_enable_out(bsig), .pixel_clock_disable_out(pclkoff), .mem_data_out(mdout),
    .sig_busy_out(busy));
  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    u_host.get(idx, v);
    chk("reg_read", exp, v);
  endtask
  task automatic wt();
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // One frame of capture: arm, open at a frame start, close at the next
  task automatic cap(input logic [7:0] ctl, output logic [15:0] r);
    logic [7:0] lo;
    logic [7:0] hi;
    u_host.put(8'h18, ctl);
    repeat (3) @(posedge clk_in);
    #1 fs = 1'b1;
    @(posedge clk_in) #1;
    fs = 1'b0;
    pv = 1'b1;
    chk("sig_busy", 1, busy);
    repeat (8) @(posedge clk_in);
    #1 pv = 1'b0;
    fs = 1'b1;
    @(posedge clk_in) #1;
    fs = 1'b0;
    u_host.get(8'h18, lo);
    chk("start_bit", 0, lo[0]);
    u_host.get(8'h19, lo);
    u_host.get(8'h1a, hi);
    r = {hi, lo};
  endtask
  initial begin
    {fs, pv, icon3, tmo, panel} = '0;
    pal_idx = 8'h00;
    attr = 6'h2d;
    seg = 4'h0;
    gmap = 2'h1;
    rgb = 3'b001;
    luma = 8'h01;
    maddr = 22'h000000;
    mdin = 64'h0123_4567_89ab_cdef;
    repeat (4) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    rchk(8'h14, 8'h00);
    rchk(8'h15, 8'h00);
    rchk(8'h13, 8'h20);
    u_host.put(8'h14, 8'ha5);
    u_host.put(8'h15, 8'h5a);
    u_host.put(8'h30, 8'hff);
    rchk(8'h14, 8'ha5);
    rchk(8'h15, 8'h5a);
    rchk(8'h30, 8'h00);
    u_host.put(8'h12, 8'hff);
    u_host.put(8'h13, 8'hff);
    rchk(8'h12, 8'h87);
    rchk(8'h13, 8'h3f);
    chk("cursor_enable", 1, cen);
    chk("cursor_large", 1, clg);
    chk("pattern_addr", {9'h1ff, 3'h7, 10'h000}, paddr);
    chk("border_entry", 9'h102, bentry);
    chk("border_attr", 0, battr);
    u_host.put(8'h12, 8'h02);
    wt();
    chk("cursor_enable", 0, cen);
    chk("cursor_large", 0, clg);
    chk("pattern_addr", {9'h1ff, 5'h1f, 8'h00}, paddr);
    chk("border_entry", {3'b000, attr}, bentry);
    chk("border_attr", 1, battr);
    for (int i = 0; i < 5; i++) begin
      pal_idx = pidx[i];
      wt();
      chk("palette_entry", pent[i], pentry);
    end
    pal_idx = 8'h04;
    icon3 = 1'b1;
    wt();
    chk("palette_reserved", 1, prsv);
    icon3 = 1'b0;
    wt();
    chk("palette_reserved", 0, prsv);
    u_host.put(8'h12, 8'h00);
    pal_idx = 8'h42;
    wt();
    chk("palette_entry", 9'h042, pentry);
    tmo = 1'b1;
    u_host.put(8'h17, 8'h84);
    wt();
    chk("read_retry", 1, retry);
    chk("blit_mmio_enable", 1, men);
    chk("mmio_segmented", 1, mseg);
    chk("subsystem_wr", 0, subwr);
    u_host.put(8'h17, 8'h4c);
    seg = 4'h3;
    maddr = 22'h3fff00;
    wt();
    chk("read_retry", 0, retry);
    chk("mmio_linear", 1, mlin);
    chk("mmio_segmented", 0, mseg);
    chk("subsystem_wr", 1, subwr);
    chk("blit_hit", 1, mhit);
    maddr = 22'h3fff24;
    wt();
    chk("blit_hit", 0, mhit);
    u_host.put(8'h18, 8'he0);
    wt();
    chk("blit_sig", 1, bsig);
    chk("pixel_clock_off", 1, pclkoff);
    chk("prng_data", 1, mdout[63:48] == mdout[15:0] && mdout != mdin);
    u_host.put(8'h18, 8'h00);
    wt();
    chk("blit_sig", 0, bsig);
    chk("pixel_clock_off", 0, pclkoff);
    chk("mem_data", mdin, mdout);
    for (int i = 0; i < 4; i++) begin
      panel = i[1];
      cap(ctls[i], res);
      chk("sig_active", nz[i], res != 16'h0000);
      chk("sig_result", {8'h00, {8{nz[i]}}}, res);
    end
    u_host.put(8'h18, 8'h02);
    rchk(8'h19, 8'h00);
    rchk(8'h1a, 8'h00);
    finish_test();
  end
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule
